/* File: core/pfp_defines.svh */
`ifndef PFP_DEFINES_SVH
`define PFP_DEFINES_SVH
// Notes on behaviour
// - Twelve-bit packed mono packs each pixel pair into exactly three bytes.
// - Packed first byte carries earlier pixel bits 11 to 4.
// - Packed middle byte: later pixel low nibble high, earlier low nibble low.
// - Packed last byte carries later pixel bits 11 to 4; then repeat.
// - Packed values unsigned, zero to 0x0FFF, code equals level.
// - Luma sample equals the pixel's real eight-bit brightness.
// - Both chroma components in mono luma/chroma output are always zero.
// - One luma per pixel, one chroma pair per second pixel.
// - Raw mosaic sends eight unprocessed sensor bits per pixel.
// - Even mosaic lines start green and alternate green, blue.
// - Odd mosaic lines start red and alternate red, green.
// - Mosaic pixel occupies one byte, in transmission order.
// - Mosaic values unsigned bytes 0x00 to 0xFF, code equals level.
// - Eight-bit mono carries one unsigned brightness byte per pixel.
`define PFP_PIX_W     12
`define PFP_BYTE_W    8
`define PFP_LINE_W    16
`define PFP_BRIGHT_HI 11
`define PFP_BRIGHT_LO 4
`define PFP_ZERO_BYTE 8'h00
`endif

/* File: core/pfp_pkg.sv */
package pfp_pkg;
	typedef enum logic [1:0] {
		PFP_FMT_MONO8      = 2'b00,
		PFP_FMT_MONO12PACK = 2'b01,
		PFP_FMT_LUMA_CHR   = 2'b10,
		PFP_FMT_MOSAIC8    = 2'b11
	} pfp_format_type;

	typedef enum logic [1:0] {
		PFP_MOS_GREEN = 2'b00,
		PFP_MOS_BLUE  = 2'b01,
		PFP_MOS_RED   = 2'b10
	} pfp_colour_type;

	typedef enum logic [2:0] {
		PFP_ST_IDLE = 3'b000,
		PFP_ST_B0   = 3'b001,
		PFP_ST_B1   = 3'b010,
		PFP_ST_B2   = 3'b011,
		PFP_ST_B3   = 3'b100
	} pfp_state_type;

	typedef struct packed {
		logic        sof;
		logic        sol;
		logic [11:0] value;
	} pfp_pixel_type;

	typedef struct packed {
		logic       sof;
		logic       sol;
		logic [1:0] colour;
		logic [7:0] data;
	} pfp_byte_type;
endpackage : pfp_pkg

/* File: core/pfp_pixel_format_packer.sv */
`include "pfp_defines.svh"
module pfp_pixel_format_packer (
	input  wire logic                   sys_clk,
	input  wire logic                   rst_n,
	input  wire pfp_pkg::pfp_format_type formatSel,
	input  wire logic                   chromaLumaFirst,
	input  wire logic                   pixValid,
	output logic                        pixReady,
	input  wire pfp_pkg::pfp_pixel_type pixIn,
	output logic                        byteValid,
	input  wire logic                   byteReady,
	output pfp_pkg::pfp_byte_type       byteOut
);

	////////////////////////////////////////////////////////////////////////
	// Frame state: format latched at frame start, line counter
	pfp_pkg::pfp_format_type fmt;
	logic                    lumaFirst;
	logic [`PFP_LINE_W-1:0]  lineNum;
	logic                    pixOdd;
	logic [11:0]             held;
	logic                    heldSof;
	logic                    heldSol;
	pfp_pkg::pfp_state_type  state;

	// Two-entry output buffer: byteOut is the head, buf1 the spare
	pfp_pkg::pfp_byte_type   buf1;
	logic                    buf1Valid;
	logic                    pushReq;
	pfp_pkg::pfp_byte_type   pushData;
	logic                    bufFull;
	logic                    pop;
	logic                    push;

	logic                    take;
	pfp_pkg::pfp_format_type curFmt;
	logic                    curLumaFirst;
	logic                    curOddLine;
	logic                    curOddPix;
	logic                    enterTrail;
	logic                    stayTrail;
	logic                    next_bufFull;

	assign bufFull = buf1Valid;
	assign pop     = byteValid && byteReady;
	assign take    = pixValid && pixReady;
	assign curFmt  = pixIn.sof ? formatSel : fmt;
	assign curLumaFirst = pixIn.sof ? chromaLumaFirst : lumaFirst;
	assign curOddLine = pixIn.sof ? 1'b0 :
		(pixIn.sol ? ~lineNum[0] : lineNum[0]);
	assign curOddPix = pixIn.sol ? 1'b0 : pixOdd;

	// A pixel is refused while trailing bytes of a pair are still owed
	assign enterTrail = take && (curFmt == pfp_pkg::PFP_FMT_LUMA_CHR ||
		(curFmt == pfp_pkg::PFP_FMT_MONO12PACK && curOddPix));
	assign stayTrail  = (state == pfp_pkg::PFP_ST_B1) && !push;
	assign next_bufFull = !pop && (buf1Valid || (byteValid && push));

	////////////////////////////////////////////////////////////////////////
	// Frame and line tracking
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			fmt       <= pfp_pkg::PFP_FMT_MONO8;
			lumaFirst <= 1'b0;
			lineNum   <= '0;
			pixOdd    <= 1'b0;
		end else if (take) begin
			fmt       <= curFmt;
			lumaFirst <= curLumaFirst;
			if (pixIn.sof)
				lineNum <= '0;
			else if (pixIn.sol)
				lineNum <= lineNum + 16'h0001;
			pixOdd <= ~curOddPix;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Byte producer: pixel in, two to four bytes out per pixel pair
	always_comb begin
		pushReq  = 1'b0;
		pushData = '0;
		case (state)
		pfp_pkg::PFP_ST_IDLE: begin
			// Registered ready already guarantees room for this byte
			if (take) begin
				pushData.sof = pixIn.sof;
				pushData.sol = pixIn.sol;
				case (curFmt)
				pfp_pkg::PFP_FMT_MONO12PACK: begin
					// Earlier pixel: high bits out now
					pushReq = !curOddPix;
					pushData.data =
						pixIn.value[`PFP_BRIGHT_HI:`PFP_BRIGHT_LO];
				end
				pfp_pkg::PFP_FMT_LUMA_CHR: begin
					pushReq = 1'b1;
					if (curOddPix)
						pushData.data = curLumaFirst ?
							pixIn.value[`PFP_BRIGHT_HI:`PFP_BRIGHT_LO] :
							`PFP_ZERO_BYTE;
					else
						pushData.data = curLumaFirst ?
							pixIn.value[`PFP_BRIGHT_HI:`PFP_BRIGHT_LO] :
							`PFP_ZERO_BYTE;
				end
				pfp_pkg::PFP_FMT_MOSAIC8: begin
					pushReq = 1'b1;
					pushData.data =
						pixIn.value[`PFP_BRIGHT_HI:`PFP_BRIGHT_LO];
					if (curOddLine)
						pushData.colour = curOddPix ? pfp_pkg::PFP_MOS_GREEN :
							pfp_pkg::PFP_MOS_RED;
					else
						pushData.colour = curOddPix ? pfp_pkg::PFP_MOS_BLUE :
							pfp_pkg::PFP_MOS_GREEN;
				end
				default: begin
					pushReq = 1'b1;
					pushData.data =
						pixIn.value[`PFP_BRIGHT_HI:`PFP_BRIGHT_LO];
				end
				endcase
				// Packed mono odd pixel emits middle byte now
				if (curFmt == pfp_pkg::PFP_FMT_MONO12PACK && curOddPix) begin
					pushReq = 1'b1;
					pushData.sof = heldSof;
					pushData.sol = heldSol;
					pushData.data = {pixIn.value[3:0], held[3:0]};
				end
			end
		end
		pfp_pkg::PFP_ST_B1: begin
			// Trailing bytes of a pair, no pixel taken
			pushReq = 1'b1;
			if (fmt == pfp_pkg::PFP_FMT_MONO12PACK)
				pushData.data =
					held[`PFP_BRIGHT_HI:`PFP_BRIGHT_LO];
			else
				pushData.data = lumaFirst ? `PFP_ZERO_BYTE :
					held[`PFP_BRIGHT_HI:`PFP_BRIGHT_LO];
		end
		default: begin
			pushReq = 1'b0;
		end
		endcase
	end

	assign push = pushReq && !bufFull;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state   <= pfp_pkg::PFP_ST_IDLE;
			held    <= 12'h000;
			heldSof <= 1'b0;
			heldSol <= 1'b0;
		end else begin
			case (state)
			pfp_pkg::PFP_ST_IDLE: begin
				if (take) begin
					if (!curOddPix) begin
						held    <= pixIn.value;
						heldSof <= pixIn.sof;
						heldSol <= pixIn.sol;
					end else if (curFmt == pfp_pkg::PFP_FMT_MONO12PACK) begin
						held  <= pixIn.value;
						state <= pfp_pkg::PFP_ST_B1;
					end
					// Luma/chroma: each pixel has a trailing byte
					if (curFmt == pfp_pkg::PFP_FMT_LUMA_CHR) begin
						held  <= pixIn.value;
						state <= pfp_pkg::PFP_ST_B1;
					end
				end
			end
			pfp_pkg::PFP_ST_B1: begin
				if (push)
					state <= pfp_pkg::PFP_ST_IDLE;
			end
			default: state <= pfp_pkg::PFP_ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Two-entry buffer; the head register drives the outputs directly
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			byteValid <= 1'b0;
			byteOut   <= '0;
			buf1      <= '0;
			buf1Valid <= 1'b0;
		end else begin
			case ({push, pop})
			2'b10: begin
				if (!byteValid) begin
					byteOut   <= pushData;
					byteValid <= 1'b1;
				end else begin
					buf1      <= pushData;
					buf1Valid <= 1'b1;
				end
			end
			2'b01: begin
				if (buf1Valid) begin
					byteOut   <= buf1;
					buf1Valid <= 1'b0;
				end else
					byteValid <= 1'b0;
			end
			2'b11: begin
				// Push is refused while full, so the spare is empty here
				byteOut <= pushData;
			end
			default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Ready is registered: it predicts an idle producer and free room
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			pixReady <= 1'b0;
		else
			pixReady <= !enterTrail && !stayTrail && !next_bufFull;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks on the byte stream and on the producer
	property p_out_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		byteValid && !byteReady |=> byteValid && $stable(byteOut);
	endproperty
	a_out_hold: assert property (p_out_hold)
		else $error("output byte changed while stalled");

	property p_spare_behind;
		@(posedge sys_clk) disable iff (!rst_n)
		buf1Valid |-> byteValid;
	endproperty
	a_spare_behind: assert property (p_spare_behind)
		else $error("spare entry filled ahead of the head");

	property p_ready_room;
		@(posedge sys_clk) disable iff (!rst_n)
		pixReady |-> state == pfp_pkg::PFP_ST_IDLE && !buf1Valid;
	endproperty
	a_ready_room: assert property (p_ready_room)
		else $error("pixel accepted without room or while bytes owed");

	property p_first_byte;
		@(posedge sys_clk) disable iff (!rst_n)
		take && curFmt == pfp_pkg::PFP_FMT_MONO12PACK && !curOddPix |->
			push && pushData.data == pixIn.value[11:4];
	endproperty
	a_first_byte: assert property (p_first_byte)
		else $error("packed first byte wrong");

	property p_mid_nibble;
		@(posedge sys_clk) disable iff (!rst_n)
		take && curFmt == pfp_pkg::PFP_FMT_MONO12PACK && curOddPix |->
			push && pushData.data == {pixIn.value[3:0], held[3:0]};
	endproperty
	a_mid_nibble: assert property (p_mid_nibble)
		else $error("packed middle byte wrong");

	property p_last_byte;
		@(posedge sys_clk) disable iff (!rst_n)
		take && curFmt == pfp_pkg::PFP_FMT_MONO12PACK && curOddPix |=>
			state == pfp_pkg::PFP_ST_B1 && held == $past(pixIn.value) &&
			pushReq && pushData.data == held[11:4];
	endproperty
	a_last_byte: assert property (p_last_byte)
		else $error("packed last byte wrong");

	property p_luma_value;
		@(posedge sys_clk) disable iff (!rst_n)
		take && curFmt == pfp_pkg::PFP_FMT_LUMA_CHR && curLumaFirst |->
			push && pushData.data == pixIn.value[11:4];
	endproperty
	a_luma_value: assert property (p_luma_value)
		else $error("luma byte differs from brightness");

	property p_chroma_zero;
		@(posedge sys_clk) disable iff (!rst_n)
		state == pfp_pkg::PFP_ST_B1 && fmt == pfp_pkg::PFP_FMT_LUMA_CHR &&
			lumaFirst |-> pushData.data == `PFP_ZERO_BYTE;
	endproperty
	a_chroma_zero: assert property (p_chroma_zero)
		else $error("chroma byte not zero");

	property p_trail_done;
		@(posedge sys_clk) disable iff (!rst_n)
		state == pfp_pkg::PFP_ST_B1 && push |=>
			state == pfp_pkg::PFP_ST_IDLE;
	endproperty
	a_trail_done: assert property (p_trail_done)
		else $error("trailing byte not followed by idle");

	property p_mosaic_start;
		@(posedge sys_clk) disable iff (!rst_n)
		take && pixIn.sof && curFmt == pfp_pkg::PFP_FMT_MOSAIC8 |->
			push && pushData.colour == pfp_pkg::PFP_MOS_GREEN;
	endproperty
	a_mosaic_start: assert property (p_mosaic_start)
		else $error("mosaic frame does not start green");

	property p_mosaic_odd;
		@(posedge sys_clk) disable iff (!rst_n)
		take && curFmt == pfp_pkg::PFP_FMT_MOSAIC8 && curOddLine &&
			!curOddPix |-> pushData.colour == pfp_pkg::PFP_MOS_RED;
	endproperty
	a_mosaic_odd: assert property (p_mosaic_odd)
		else $error("odd mosaic line does not start red");

	property p_frame_line;
		@(posedge sys_clk) disable iff (!rst_n)
		take && pixIn.sof |=> lineNum == '0 && fmt == $past(formatSel);
	endproperty
	a_frame_line: assert property (p_frame_line)
		else $error("frame start did not reset line or latch format");

endmodule : pfp_pixel_format_packer

/* File: dv/pfp_byte_sink.sv */
module pfp_byte_sink (
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	input  wire logic                  slow,
	input  wire logic                  byteValid,
	output logic                       byteReady,
	input  wire pfp_pkg::pfp_byte_type byteOut
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0]            phase;
	pfp_pkg::pfp_byte_type got[$];
	////////////////////////////////////////
	// Collect accepted bytes; stall one cycle in four when slow
	always @(posedge sys_clk) begin
		phase <= rst_n ? phase + 2'h1 : 2'h0;
		if (rst_n && byteValid && byteReady) got.push_back(byteOut);
	end
	assign byteReady = !(slow && phase == 2'h3);
endmodule : pfp_byte_sink

/* File: dv/pfp_pixel_format_packer_tb.sv */
module pfp_pixel_format_packer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    sys_clk = 1'b0;
	logic                    rst_n = 1'b0;
	pfp_pkg::pfp_format_type formatSel = pfp_pkg::PFP_FMT_MONO8;
	logic                    chromaLumaFirst = 1'b0;
	logic                    pixValid = 1'b0;
	logic                    slow = 1'b0;
	logic                    took = 1'b0;
	logic                    pixReady;
	logic                    byteValid;
	logic                    byteReady;
	pfp_pkg::pfp_pixel_type  pixIn = '0;
	pfp_pkg::pfp_byte_type   byteOut;
	pfp_pkg::pfp_pixel_type  pq[$];
	logic [9:0]              eq[$];
	int                      fails = 0;
	int                      num_checks = 0;
	int                      cycles = 0;
	always #4 sys_clk = ~sys_clk;
	pfp_pixel_format_packer i_pfp_pixel_format_packer (.sys_clk(sys_clk),
		.rst_n(rst_n), .formatSel(formatSel), .chromaLumaFirst(chromaLumaFirst),
		.pixValid(pixValid), .pixReady(pixReady), .pixIn(pixIn),
		.byteValid(byteValid), .byteReady(byteReady), .byteOut(byteOut));
	pfp_byte_sink i_pfp_byte_sink (.sys_clk(sys_clk), .rst_n(rst_n),
		.slow(slow), .byteValid(byteValid), .byteReady(byteReady),
		.byteOut(byteOut));
	always @(posedge sys_clk) begin
		took <= pixValid && pixReady;
		cycles++;
		if (cycles == 5000) begin
			fails++;
			end_of_test();
		end
	end
	////////////////////////////////////////
	task check(string what, logic [9:0] seen, logic [9:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	function void px(logic f, logic l, logic [11:0] v);
		pq.push_back({f, l, v});
	endfunction : px
	function void ex(logic [1:0] c, logic [7:0] d);
		eq.push_back({c, d});
	endfunction : ex
	task run(string name, pfp_pkg::pfp_format_type f, logic clf, logic mos);
		int w;
		pfp_pkg::pfp_byte_type b;
		formatSel = f;
		chromaLumaFirst = clf;
		i_pfp_byte_sink.got.delete();
		foreach (pq[i]) begin
			pixIn = pq[i];
			pixValid = 1'b1;
			do begin
				@(posedge sys_clk);
				#1;
			end while (!took);
		end
		pixValid = 1'b0;
		for (w = 0; w < 200 && i_pfp_byte_sink.got.size() < eq.size(); w++)
			@(posedge sys_clk);
		// A few more cycles so that surplus bytes are caught as well
		repeat (4) @(posedge sys_clk);
		#1;
		check("count", 10'(i_pfp_byte_sink.got.size()), 10'(eq.size()));
		b = i_pfp_byte_sink.got[0];
		check("start", {8'h00, b.sof, b.sol}, 10'h003);
		foreach (eq[i]) begin
			b = i_pfp_byte_sink.got[i];
			check(name, {mos ? b.colour : 2'h0, b.data}, eq[i]);
		end
		$display("test %s done", name);
		pq.delete();
		eq.delete();
	endtask : run
	task t_packed;
		px(1'b1, 1'b1, 12'hABC);
		px(1'b0, 1'b0, 12'h123);
		px(1'b0, 1'b0, 12'hFFF);
		px(1'b0, 1'b0, 12'h000);
		ex(2'h0, 8'hAB);
		ex(2'h0, 8'h3C);
		ex(2'h0, 8'h12);
		ex(2'h0, 8'hFF);
		ex(2'h0, 8'h0F);
		ex(2'h0, 8'h00);
		run("packed", pfp_pkg::PFP_FMT_MONO12PACK, 1'b0, 1'b0);
	endtask : t_packed
	task t_luma;
		for (int c = 0; c < 2; c++) begin
			px(1'b1, 1'b1, 12'h5A7);
			px(1'b0, 1'b0, 12'hC31);
			// Select low puts chroma first, select high puts luma first
			if (c == 0) begin
				ex(2'h0, 8'h00);
				ex(2'h0, 8'h5A);
				ex(2'h0, 8'h00);
				ex(2'h0, 8'hC3);
			end else begin
				ex(2'h0, 8'h5A);
				ex(2'h0, 8'h00);
				ex(2'h0, 8'hC3);
				ex(2'h0, 8'h00);
			end
			run("luma", pfp_pkg::PFP_FMT_LUMA_CHR, c[0], 1'b0);
		end
	endtask : t_luma
	task t_mosaic;
		logic [11:0] v;
		slow = 1'b1;
		for (int ln = 0; ln < 3; ln++)
			for (int p = 0; p < 4; p++) begin
				v = (ln == 0 && p == 0) ? 12'hFFF : {4'(ln), 4'(p), 4'h5};
				px(p == 0 && ln != 1, p == 0, v);
				if (ln == 1)
					ex(p % 2 ? pfp_pkg::PFP_MOS_GREEN : pfp_pkg::PFP_MOS_RED,
						v[11:4]);
				else
					ex(p % 2 ? pfp_pkg::PFP_MOS_BLUE : pfp_pkg::PFP_MOS_GREEN,
						v[11:4]);
			end
		run("mosaic", pfp_pkg::PFP_FMT_MOSAIC8, 1'b0, 1'b1);
		slow = 1'b0;
	endtask : t_mosaic
	task t_mono8;
		px(1'b1, 1'b1, 12'h000);
		px(1'b0, 1'b0, 12'hFFF);
		px(1'b0, 1'b0, 12'h7E1);
		ex(2'h0, 8'h00);
		ex(2'h0, 8'hFF);
		ex(2'h0, 8'h7E);
		run("mono8", pfp_pkg::PFP_FMT_MONO8, 1'b0, 1'b0);
	endtask : t_mono8
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (6) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		t_packed();
		t_luma();
		t_mosaic();
		t_mono8();
		end_of_test();
	end
endmodule : pfp_pixel_format_packer_tb
